// ---- hdl/mspc_top.sv ----
`include "mspc_cfg.svh"

// What this block does
// - bit 7 enables wake-on-motion detection
// - bit 6 selects compare against previous sample
// - fifo enable gates serial fifo access
// - fifo enable never blocks internal fifo writes
// - i2c disable bit forces spi-only interface
// - fifo reset pulses, self-clears after oscillator cycle
// - path clear resets paths, clears sensor data
// - device reset restores defaults then self-clears
// - sleep bit resets to one, chip sleeps
// - duty cycling wakes at divider rate, samples
// - no enabled accel axis: wake, no sample
// - gyro standby keeps drive, pll; sense off
// - thermometer off bit disables temperature sensor
// - codes 0,6 oscillator; 1-5 pll if ready
// - code 7 stops clock, holds timing reset
module mspc_top #(
	parameter int BASE_CYCLES = `MSPC_BASE_CYCLES
) (
	input  wire logic                  sys_clk,
	input  wire logic                  reset_n,
	input  wire mspc_pkg::mspc_reg_req_t reg_req,
	input  wire logic [7:0]            sample_rate_divider,
	input  wire logic [2:0]            accel_axis_on,
	input  wire logic                  sample_fifo_source_en,
	input  wire logic                  pll_ready,
	output logic [7:0]                 reg_rdata_ff,
	output logic                       reg_rvalid_ff,
	output logic                       wake_motion_enable_ff,
	output logic                       motion_compare_mode_ff,
	output logic                       motion_processor_enable_ff,
	output logic                       motion_processor_clear_ff,
	output logic                       serial_fifo_access_ff,
	output logic                       sample_fifo_write_en_ff,
	output logic                       i2c_target_disable_ff,
	output logic                       fifo_reset_ff,
	output logic                       sensor_path_clear_ff,
	output logic                       device_reset_ff,
	output logic                       wake_pulse_ff,
	output logic                       accel_sample_ff,
	output mspc_pkg::mspc_power_t      power_ff,
	output mspc_pkg::mspc_clk_t        clock_ff
);

	import mspc_pkg::*;

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic [7:0]        mot_ff;
	logic [7:0]        usr_ff;
	logic [7:0]        pwr_ff;
	logic [7:0]        nxt_mot;
	logic [7:0]        nxt_usr;
	logic [7:0]        nxt_pwr;
	logic [7:0]        nxt_rdata;
	logic              nxt_rvalid;
	mspc_rst_state_t   rst_state_ff;
	mspc_rst_state_t   nxt_rst_state;
	logic [2:0]        rst_cnt_ff;
	logic [2:0]        nxt_rst_cnt;
	logic              osc_tick;
	logic              base_tick;
	logic              wake_tick;
	logic              wr_mot;
	logic              wr_usr;
	logic              wr_pwr;
	logic              clearing;
	logic              rst_request;
	logic              cycle_run;

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	assign wr_mot   = reg_req.wr && (reg_req.addr == `MSPC_OFS_MOTION_CTRL);
	assign wr_usr   = reg_req.wr && (reg_req.addr == `MSPC_OFS_USER_CTRL);
	assign wr_pwr   = reg_req.wr && (reg_req.addr == `MSPC_OFS_POWER_ONE);
	assign clearing = (rst_state_ff == MSPC_CLEARING);
	// a reset request in the release cycle restarts the sequence: set beats clear
	assign rst_request = wr_pwr && reg_req.wdata[`MSPC_PWR_DEV_RESET];

	// ------------------------------------------------------------
	// slower rates
	// ------------------------------------------------------------
	// 20 MHz oscillator cycle for the self-clearing fifo reset
	mspc_tick_div #(
		.DIV (`MSPC_OSC_DIV),
		.W   (4)
	) u_osc_div (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.run     (1'b1),
		.tick_ff (osc_tick)
	);

	// base sample period; the divider register stretches it
	mspc_tick_div #(
		.DIV (BASE_CYCLES),
		.W   (24)
	) u_base_div (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.run     (cycle_run),
		.tick_ff (base_tick)
	);

	// duty cycling only while cycle set and neither sleep nor standby
	assign cycle_run = pwr_ff[`MSPC_PWR_CYCLE] && !pwr_ff[`MSPC_PWR_SLEEP]
		&& !pwr_ff[`MSPC_PWR_GYRO_STBY];

	mspc_duty_cycle #(
		.DW (8)
	) u_duty (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.enable  (cycle_run),
		.base_tick (base_tick),
		.divider (sample_rate_divider),
		.wake_ff (wake_tick)
	);

	// ------------------------------------------------------------
	// device reset sequencer
	// ------------------------------------------------------------
	// the reset bit reads back 1 until the release cycle is over
	always_comb begin
		nxt_rst_state = rst_state_ff;
		nxt_rst_cnt   = rst_cnt_ff;
		unique case (rst_state_ff)
			MSPC_RUN: begin
				if (rst_request) begin
					nxt_rst_state = MSPC_CLEARING;
					nxt_rst_cnt   = 3'(`MSPC_DEVRST_CYCLES - 1);
				end
			end
			MSPC_CLEARING: begin
				if (rst_cnt_ff == 3'h0) begin
					nxt_rst_state = MSPC_RELEASE;
				end else begin
					nxt_rst_cnt = rst_cnt_ff - 1'b1;
				end
			end
			MSPC_RELEASE: begin
				if (rst_request) begin
					nxt_rst_state = MSPC_CLEARING;
					nxt_rst_cnt   = 3'(`MSPC_DEVRST_CYCLES - 1);
				end else begin
					nxt_rst_state = MSPC_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_state_ff <= MSPC_RUN;
			rst_cnt_ff   <= 3'h0;
		end else begin
			rst_state_ff <= nxt_rst_state;
			rst_cnt_ff   <= nxt_rst_cnt;
		end
	end

	// ------------------------------------------------------------
	// register next values
	// ------------------------------------------------------------
	// writes during the clearing phase are dropped: defaults win
	always_comb begin
		nxt_mot = mot_ff;
		nxt_usr = usr_ff;
		nxt_pwr = pwr_ff;
		// self-clearing strobes drop on the oscillator cycle edge
		if (osc_tick) begin
			nxt_usr[`MSPC_USR_FIFO_RESET] = 1'b0;
			nxt_usr[`MSPC_USR_PATH_CLEAR] = 1'b0;
			nxt_usr[`MSPC_USR_MP_CLEAR]   = 1'b0;
		end
		if (wr_mot) begin
			nxt_mot = reg_req.wdata & `MSPC_MOT_MASK;
		end
		if (wr_usr) begin
			// a new strobe in the tick cycle survives: set beats clear
			nxt_usr = (reg_req.wdata & `MSPC_USR_MASK) | (nxt_usr & 8'h0d);
		end
		if (wr_pwr) begin
			nxt_pwr = reg_req.wdata & `MSPC_PWR_MASK;
		end
		if (clearing) begin
			nxt_mot = `MSPC_MOT_RESET;
			nxt_usr = `MSPC_USR_RESET;
			nxt_pwr = `MSPC_PWR_RESET | 8'h80;
		end else if (rst_state_ff == MSPC_RELEASE && !rst_request) begin
			nxt_pwr[`MSPC_PWR_DEV_RESET] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mot_ff <= `MSPC_MOT_RESET;
			usr_ff <= `MSPC_USR_RESET;
			pwr_ff <= `MSPC_PWR_RESET;
		end else begin
			mot_ff <= nxt_mot;
			usr_ff <= nxt_usr;
			pwr_ff <= nxt_pwr;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// unmapped addresses read zero, answer one cycle after the strobe
	always_comb begin
		nxt_rvalid = reg_req.rd;
		nxt_rdata  = 8'h00;
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				`MSPC_OFS_MOTION_CTRL: nxt_rdata = mot_ff;
				`MSPC_OFS_USER_CTRL:   nxt_rdata = usr_ff;
				`MSPC_OFS_POWER_ONE:   nxt_rdata = pwr_ff;
				default:               nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_ff  <= 8'h00;
			reg_rvalid_ff <= 1'b0;
		end else begin
			reg_rdata_ff  <= nxt_rdata;
			reg_rvalid_ff <= nxt_rvalid;
		end
	end

	// ------------------------------------------------------------
	// control outputs
	// ------------------------------------------------------------
	mspc_power_t nxt_power;
	mspc_clk_t   nxt_clock;
	logic [2:0]  clk_code;

	assign clk_code = pwr_ff[`MSPC_PWR_CLK_HI:`MSPC_PWR_CLK_LO];

	// power steering; sleep overrides every analog enable
	always_comb begin
		nxt_power.chip_sleep     = pwr_ff[`MSPC_PWR_SLEEP];
		nxt_power.gyro_drive_on  = !pwr_ff[`MSPC_PWR_SLEEP];
		nxt_power.pll_on         = !pwr_ff[`MSPC_PWR_SLEEP];
		nxt_power.gyro_sense_on  = !pwr_ff[`MSPC_PWR_SLEEP]
			&& !pwr_ff[`MSPC_PWR_GYRO_STBY];
		nxt_power.thermometer_on = !pwr_ff[`MSPC_PWR_SLEEP]
			&& !pwr_ff[`MSPC_PWR_TEMP_OFF];
	end

	// clock choice: fallback is live, so a lost pll drops to oscillator
	always_comb begin
		nxt_clock.use_pll          = 1'b0;
		nxt_clock.clock_stopped    = 1'b0;
		nxt_clock.timing_gen_reset = 1'b0;
		if (clk_code == `MSPC_CLK_STOP) begin
			nxt_clock.clock_stopped    = 1'b1;
			nxt_clock.timing_gen_reset = 1'b1;
		end else if (clk_code != `MSPC_CLK_OSC_A && clk_code != `MSPC_CLK_OSC_B) begin
			nxt_clock.use_pll = pll_ready;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_motion_enable_ff      <= 1'b0;
			motion_compare_mode_ff     <= 1'b0;
			motion_processor_enable_ff <= 1'b0;
			motion_processor_clear_ff  <= 1'b0;
			serial_fifo_access_ff      <= 1'b0;
			sample_fifo_write_en_ff    <= 1'b0;
			i2c_target_disable_ff      <= 1'b0;
			fifo_reset_ff              <= 1'b0;
			sensor_path_clear_ff       <= 1'b0;
			device_reset_ff            <= 1'b0;
			wake_pulse_ff              <= 1'b0;
			accel_sample_ff            <= 1'b0;
			power_ff                   <= '{chip_sleep: 1'b1, default: 1'b0};
			clock_ff                   <= '0;
		end else begin
			wake_motion_enable_ff      <= mot_ff[`MSPC_MOT_ENABLE];
			// mode 0 is not to be used; passed through unchanged
			motion_compare_mode_ff     <= mot_ff[`MSPC_MOT_MODE];
			motion_processor_enable_ff <= usr_ff[`MSPC_USR_MP_ENABLE];
			motion_processor_clear_ff  <= usr_ff[`MSPC_USR_MP_CLEAR];
			serial_fifo_access_ff      <= usr_ff[`MSPC_USR_FIFO_ENABLE];
			// internal writes follow the source enable only
			sample_fifo_write_en_ff    <= sample_fifo_source_en;
			i2c_target_disable_ff      <= usr_ff[`MSPC_USR_I2C_DISABLE];
			fifo_reset_ff              <= usr_ff[`MSPC_USR_FIFO_RESET];
			sensor_path_clear_ff       <= usr_ff[`MSPC_USR_PATH_CLEAR];
			device_reset_ff            <= clearing;
			wake_pulse_ff              <= wake_tick;
			accel_sample_ff            <= wake_tick && (accel_axis_on != 3'h0);
			power_ff                   <= nxt_power;
			clock_ff                   <= nxt_clock;
		end
	end

endmodule

// ---- hdl/mspc_cfg.svh ----
`ifndef MSPC_CFG_SVH
`define MSPC_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MSPC_OFS_MOTION_CTRL   8'h69
`define MSPC_OFS_USER_CTRL     8'h6a
`define MSPC_OFS_POWER_ONE     8'h6b

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MSPC_MOT_ENABLE        7
`define MSPC_MOT_MODE          6
`define MSPC_USR_MP_ENABLE     7
`define MSPC_USR_FIFO_ENABLE   6
`define MSPC_USR_I2C_DISABLE   4
`define MSPC_USR_MP_CLEAR      3
`define MSPC_USR_FIFO_RESET    2
`define MSPC_USR_PATH_CLEAR    0
`define MSPC_PWR_DEV_RESET     7
`define MSPC_PWR_SLEEP         6
`define MSPC_PWR_CYCLE         5
`define MSPC_PWR_GYRO_STBY     4
`define MSPC_PWR_TEMP_OFF      3
`define MSPC_PWR_CLK_HI        2
`define MSPC_PWR_CLK_LO        0

// ----------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------
`define MSPC_MOT_MASK          8'hc0
`define MSPC_USR_MASK          8'hdd
`define MSPC_PWR_MASK          8'hff
`define MSPC_MOT_RESET         8'h00
`define MSPC_USR_RESET         8'h00
`define MSPC_PWR_RESET         8'h40

// ----------------------------------------------------------------
// clock source codes
// ----------------------------------------------------------------
`define MSPC_CLK_OSC_A         3'h0
`define MSPC_CLK_OSC_B         3'h6
`define MSPC_CLK_STOP          3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MSPC_SYS_HZ            100000000
`define MSPC_OSC_HZ            20000000
`define MSPC_OSC_DIV           (`MSPC_SYS_HZ / `MSPC_OSC_HZ)
`define MSPC_BASE_PERIOD_US    1000
`define MSPC_BASE_CYCLES       (`MSPC_BASE_PERIOD_US * (`MSPC_SYS_HZ / 1000000))
`define MSPC_DEVRST_CYCLES     4

`endif

// ---- hdl/mspc_pkg.sv ----
package mspc_pkg;

	// device reset sequencer
	typedef enum logic [1:0] {
		MSPC_RUN,
		MSPC_CLEARING,
		MSPC_RELEASE
	} mspc_rst_state_t;

	// clock selection result
	typedef struct packed {
		logic use_pll;
		logic clock_stopped;
		logic timing_gen_reset;
	} mspc_clk_t;

	// analog power steering
	typedef struct packed {
		logic chip_sleep;
		logic gyro_drive_on;
		logic pll_on;
		logic gyro_sense_on;
		logic thermometer_on;
	} mspc_power_t;

	// register access port
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mspc_reg_req_t;

endpackage

// ---- hdl/mspc_tick_div.sv ----
`include "mspc_cfg.svh"

// free divider producing one-cycle enable pulses
module mspc_tick_div #(
	parameter int DIV = `MSPC_OSC_DIV,
	parameter int W   = 24
) (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic run,
	output logic      tick_ff
);

	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic         nxt_tick;

	// count to DIV-1 then pulse; idle holds zero so restart is aligned
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_tick = 1'b0;
		if (!run) begin
			nxt_cnt = '0;
		end else if (cnt_ff == W'(DIV - 1)) begin
			nxt_cnt  = '0;
			nxt_tick = 1'b1;
		end else begin
			nxt_cnt = cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

endmodule

// ---- hdl/mspc_duty_cycle.sv ----
// wake timer: one wake pulse every (divider + 1) base ticks
module mspc_duty_cycle #(
	parameter int DW = 8
) (
	input  wire logic          sys_clk,
	input  wire logic          reset_n,
	input  wire logic          enable,
	input  wire logic          base_tick,
	input  wire logic [DW-1:0] divider,
	output logic               wake_ff
);

	logic [DW-1:0] cnt_ff;
	logic [DW-1:0] nxt_cnt;
	logic          nxt_wake;

	// divider change takes effect at the next wake boundary or compare
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_wake = 1'b0;
		if (!enable) begin
			nxt_cnt = '0;
		end else if (base_tick) begin
			if (cnt_ff >= divider) begin
				nxt_cnt  = '0;
				nxt_wake = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff  <= '0;
			wake_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			wake_ff <= nxt_wake;
		end
	end

endmodule

// ---- testbench/mspc_top_properties.sv ----
// watches the register port and control outputs of the top level
module mspc_top_chk (
	input wire logic                    sys_clk,
	input wire logic                    reset_n,
	input wire mspc_pkg::mspc_reg_req_t reg_req,
	input wire logic [2:0]              accel_axis_on,
	input wire logic                    sample_fifo_source_en,
	input wire logic                    reg_rvalid_ff,
	input wire logic                    wake_motion_enable_ff,
	input wire logic                    i2c_target_disable_ff,
	input wire logic                    serial_fifo_access_ff,
	input wire logic                    sample_fifo_write_en_ff,
	input wire logic                    fifo_reset_ff,
	input wire logic                    device_reset_ff,
	input wire logic                    wake_pulse_ff,
	input wire logic                    accel_sample_ff,
	input wire mspc_pkg::mspc_power_t   power_ff,
	input wire mspc_pkg::mspc_clk_t     clock_ff
);
	import mspc_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// power write that clears sleep and does not request device reset
	logic w6b;
	assign w6b = reg_req.wr && reg_req.addr == 8'h6b && !reg_req.wdata[7] && !reg_req.wdata[6];

	chk_read_answer: assert property (reg_req.rd |=> reg_rvalid_ff)
		else $error("read not answered");
	chk_wake_enable: assert property (reg_req.wr && reg_req.addr == 8'h69 |->
		##2 wake_motion_enable_ff == $past(reg_req.wdata[7], 2)) else $error("wake enable");
	chk_i2c_disable: assert property (reg_req.wr && reg_req.addr == 8'h6a |->
		##2 i2c_target_disable_ff == $past(reg_req.wdata[4], 2)) else $error("i2c disable");
	chk_fifo_gate: assert property (sample_fifo_source_en && !serial_fifo_access_ff
		|=> sample_fifo_write_en_ff) else $error("internal fifo writes blocked");
	chk_fifo_clear: assert property ($rose(fifo_reset_ff) |-> ##[1:6] !fifo_reset_ff)
		else $error("fifo reset stuck");
	chk_devrst_len: assert property ($rose(device_reset_ff) |->
		device_reset_ff[*4] ##1 !device_reset_ff) else $error("device reset length");
	chk_sleep_gates: assert property (power_ff.chip_sleep |-> !(power_ff.gyro_drive_on ||
		power_ff.gyro_sense_on || power_ff.thermometer_on)) else $error("awake in sleep");
	chk_gyro_standby: assert property (w6b && reg_req.wdata[4] |-> ##2 power_ff.gyro_drive_on
		&& power_ff.pll_on && !power_ff.gyro_sense_on) else $error("gyro standby");
	chk_temp_off: assert property (w6b && reg_req.wdata[3] |-> ##2 !power_ff.thermometer_on)
		else $error("thermometer still on");
	chk_clock_stop: assert property (w6b && reg_req.wdata[2:0] == 3'h7 |->
		##2 clock_ff.clock_stopped && clock_ff.timing_gen_reset) else $error("clock stop");
	chk_sample_wake: assert property (accel_sample_ff |-> wake_pulse_ff)
		else $error("sample without wake");
	chk_no_axis: assert property (wake_pulse_ff && accel_axis_on == 3'h0 &&
		$past(accel_axis_on) == 3'h0 |-> !accel_sample_ff) else $error("sample with no axis");
endmodule

bind mspc_top mspc_top_chk u_chk (
	.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req),
	.accel_axis_on(accel_axis_on), .sample_fifo_source_en(sample_fifo_source_en),
	.reg_rvalid_ff(reg_rvalid_ff), .wake_motion_enable_ff(wake_motion_enable_ff),
	.i2c_target_disable_ff(i2c_target_disable_ff),
	.serial_fifo_access_ff(serial_fifo_access_ff),
	.sample_fifo_write_en_ff(sample_fifo_write_en_ff), .fifo_reset_ff(fifo_reset_ff),
	.device_reset_ff(device_reset_ff), .wake_pulse_ff(wake_pulse_ff),
	.accel_sample_ff(accel_sample_ff), .power_ff(power_ff), .clock_ff(clock_ff)
);

// ---- testbench/mspc_host.sv ----
// host processor issuing single-byte register cycles
module mspc_host (
	input wire logic                sys_clk,
	input wire logic                reg_rvalid_ff,
	input wire logic [7:0]          reg_rdata_ff,
	output mspc_pkg::mspc_reg_req_t reg_req
);
	timeunit 1ns;
	timeprecision 1ps;
	import mspc_pkg::*;

	initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h5a, wdata: 8'ha5};

	// request held across exactly one taking edge; released lines show garbage
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = d;
		@(posedge sys_clk);
		#1;
		reg_req.wr = 1'b0;
		reg_req.addr = ~a;
		reg_req.wdata = ~d;
	endtask

	// answer is registered, so it shows just after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge sys_clk);
		#1;
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		@(posedge sys_clk);
		#1;
		ok = reg_rvalid_ff;
		d = reg_rdata_ff;
		reg_req.rd = 1'b0;
		reg_req.addr = ~a;
	endtask

	// pll-backed clock before trusting gyro data
	task automatic clk_setup();
		wr(8'h6b, 8'h01);
	endtask
endmodule

// ---- testbench/mspc_top_bench.sv ----
module mspc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import mspc_pkg::*;

	logic                  sys_clk, reset_n, sample_fifo_source_en, pll_ready;
	logic [7:0]            sample_rate_divider, reg_rdata_ff;
	logic [2:0]            accel_axis_on;
	logic                  reg_rvalid_ff, wake_motion_enable_ff, motion_compare_mode_ff;
	logic                  serial_fifo_access_ff, sample_fifo_write_en_ff, i2c_target_disable_ff;
	logic                  fifo_reset_ff, sensor_path_clear_ff, device_reset_ff;
	logic                  wake_pulse_ff, accel_sample_ff;
	logic                  motion_processor_enable_ff, motion_processor_clear_ff;
	mspc_reg_req_t         reg_req;
	mspc_power_t           power_ff;
	mspc_clk_t             clock_ff;
	int                    err_count = 0, n_checks = 0, n, c;

	// short base period keeps duty-cycle runs brief
	mspc_top #(.BASE_CYCLES(20)) DUT (
		.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req),
		.sample_rate_divider(sample_rate_divider), .accel_axis_on(accel_axis_on),
		.sample_fifo_source_en(sample_fifo_source_en), .pll_ready(pll_ready),
		.reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
		.wake_motion_enable_ff(wake_motion_enable_ff),
		.motion_compare_mode_ff(motion_compare_mode_ff),
		.motion_processor_enable_ff(motion_processor_enable_ff),
		.motion_processor_clear_ff(motion_processor_clear_ff),
		.serial_fifo_access_ff(serial_fifo_access_ff),
		.sample_fifo_write_en_ff(sample_fifo_write_en_ff),
		.i2c_target_disable_ff(i2c_target_disable_ff), .fifo_reset_ff(fifo_reset_ff),
		.sensor_path_clear_ff(sensor_path_clear_ff), .device_reset_ff(device_reset_ff),
		.wake_pulse_ff(wake_pulse_ff), .accel_sample_ff(accel_sample_ff),
		.power_ff(power_ff), .clock_ff(clock_ff)
	);
	mspc_host host (.sys_clk(sys_clk), .reg_rvalid_ff(reg_rvalid_ff),
		.reg_rdata_ff(reg_rdata_ff), .reg_req(reg_req));

	// ----------------------------------------
	// checking helpers
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string m);
		logic [7:0] d;
		logic       ok;
		host.rd(a, d, ok);
		chk({7'h0, ok}, 8'h01, m);
		chk(d, e, m);
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: sig = fifo_reset_ff;
			1: sig = !fifo_reset_ff;
			2: sig = wake_pulse_ff;
			3: sig = device_reset_ff;
			4: sig = !device_reset_ff;
			default: sig = sensor_path_clear_ff;
		endcase
	endfunction

	// bounded wait; running out ends the run
	task automatic wait_for(input int s, input int lim, output int k);
		k = 0;
		while (sig(s) !== 1'b1 && k < lim) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		if (sig(s) !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED at %0t: timeout on %0d", $time, s);
			close_out();
		end
	endtask

	// outputs trail the register by one edge
	task automatic lag();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		sample_rate_divider = 8'h01;
		accel_axis_on = 3'h1;
		sample_fifo_source_en = 1'b0;
		pll_ready = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		reset_n = 1'b1;
		rd_chk(8'h6b, 8'h40, "power default");
		chk({3'h0, power_ff}, 8'h10, "asleep");
		host.wr(8'h69, 8'hff);
		rd_chk(8'h69, 8'hc0, "motion mask");
		chk({6'h0, wake_motion_enable_ff, motion_compare_mode_ff}, 8'h03, "motion");
		host.wr(8'h6a, 8'hf2);
		rd_chk(8'h6a, 8'hd0, "user mask");
		chk({5'h0, motion_processor_enable_ff, serial_fifo_access_ff, i2c_target_disable_ff},
			8'h07, "user");
		rd_chk(8'h70, 8'h00, "unmapped");
		host.wr(8'h6a, 8'h04);
		wait_for(0, 4, n);
		wait_for(1, 8, n);
		rd_chk(8'h6a, 8'h00, "fifo reset clear");
		sample_fifo_source_en = 1'b1;
		lag();
		chk({6'h0, serial_fifo_access_ff, sample_fifo_write_en_ff}, 8'h01, "fifo");
		host.wr(8'h6a, 8'h09);
		wait_for(5, 4, n);
		chk({6'h0, sensor_path_clear_ff, motion_processor_clear_ff}, 8'h03, "strobes");
		repeat (8) @(posedge sys_clk);
		rd_chk(8'h6a, 8'h00, "path clear");
		host.wr(8'h6b, 8'h18);
		lag();
		chk({3'h0, power_ff}, 8'h0c, "standby");
		pll_ready = 1'b1;
		for (c = 0; c < 8; c++) begin
			host.wr(8'h6b, {5'h0, c[2:0]});
			lag();
			chk({5'h0, clock_ff}, {5'h0, c > 0 && c < 6, c == 7, c == 7}, "clk");
		end
		host.clk_setup();
		pll_ready = 1'b0;
		lag();
		chk({6'h0, clock_ff.use_pll, power_ff.thermometer_on}, 8'h01, "fallback");
		host.wr(8'h6b, 8'h20);
		wait_for(2, 200, n);
		chk({7'h0, accel_sample_ff}, 8'h01, "sample");
		@(posedge sys_clk);
		#1;
		wait_for(2, 200, n);
		chk(8'(n + 1), 8'd40, "wake period");
		accel_axis_on = 3'h0;
		@(posedge sys_clk);
		#1;
		wait_for(2, 200, n);
		chk({7'h0, accel_sample_ff}, 8'h00, "no axis");
		host.wr(8'h6b, 8'h60);
		lag();
		n = 0;
		repeat (100) begin
			@(posedge sys_clk);
			#1;
			if (wake_pulse_ff === 1'b1)
				n++;
		end
		chk(8'(n), 8'h00, "asleep wakes");
		host.wr(8'h69, 8'hc0);
		host.wr(8'h6b, 8'h80);
		wait_for(3, 4, n);
		wait_for(4, 8, n);
		rd_chk(8'h6b, 8'h40, "reset power");
		rd_chk(8'h69, 8'h00, "reset motion");
		close_out();
	end
endmodule
